//--- jac_node_claim.sv
// Two-node CAN port control and address claim engine with APB registers
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - Reset leaves ports off, no address claimed
// - Two independent nodes, one per bus
// - Default name and preferred address 0x1C
// - Claim starts only when bound and on
// - Setup writes locked while port on bus
// - Node online only after claim succeeds
// - No traffic until online, drop outgoing
// - Disabled reports count 0, address 0xFE
// - Claim start reports count 1 and address
// - Lost attempt steps to next alternative address
// - Range exhausted: failed, 0xFE, stop
// - Higher-priority contender bumps node, reclaim
// - Commanded address adopted, claiming then claimed
// - Restart discards commanded address
// - Lower command port number transmits first
// - Transport both ways, NMEA2000 output only
// - Command ports default to NMEA2000 only
// - Six broadcast parameter groups emitted
// - Bit-rate chosen at switch-on, 250k default
module jac_node_claim
  import jac_pkg::*;
#(
  parameter int CLAIM_WAIT = CLAIM_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Claim link per node, from CAN message layer
  output logic      [NODES-1:0]  claim_send,
  output logic      [NODES-1:0][7:0] claim_addr,
  input  wire logic [NODES-1:0]  contend,
  input  wire logic [NODES-1:0]  cmd_addr_valid,
  input  wire logic [NODES-1:0][7:0] cmd_addr,
  // Port physical control
  output logic      [NODES-1:0]  port_enable,
  output logic      [NODES-1:0][1:0] port_rate,
  // Traffic gating per node
  input  wire logic [NODES-1:0]  rx_valid,
  input  wire logic [NODES-1:0]  rx_is_nmea,
  output logic      [NODES-1:0]  rx_accept,
  // Command port transmit requests, index is port number
  input  wire logic [NODES-1:0]  tx_req,
  input  wire logic [NODES-1:0]  tx_node,
  input  wire logic [17:0]       tx_pg,
  output logic      [NODES-1:0]  tx_grant,
  output logic      [NODES-1:0]  tx_drop
);

  // Broadcast groups this node may emit; anything else is refused on NMEA2000-only ports
  localparam logic [17:0] PG_LIST [NPG] = '{PG_TIME, PG_POS_RAP, PG_COG_SOG,
                                            PG_DELTA, PG_POS, PG_DIFF};

  function automatic logic pg_supported(input logic [17:0] pg);
    pg_supported = 1'b0;
    for (int i = 0; i < NPG; i++) begin
      if (pg == PG_LIST[i])
        pg_supported = 1'b1;
    end
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // Status field code of an engine state, shared by both status words
  function automatic logic [1:0] status_code(input jac_state_e s);
    unique case (s)
      JAC_CLM:  status_code = ST_CLAIMING;
      JAC_OWN:  status_code = ST_CLAIMED;
      JAC_FAIL: status_code = ST_FAILED;
      default:  status_code = ST_DISABLED;
    endcase
  endfunction

  localparam logic [31:0] NAME_RST = {2'h0, DEF_IND_GRP, DEF_DEV_INST,
                                      DEF_DEV_CLS, DEF_FUNC, DEF_FN_INST,
                                      DEF_ECU_INST};
  localparam logic [31:0] ADDR_RST = {8'h00, DEF_ADDR, DEF_ADDR, DEF_ADDR};
  // Port off, unbound, node 0, rate at its default
  localparam logic [5:0]  PORT_RST = {3'h0, DEF_RATE, 1'b0};

  // Configuration registers
  logic [NODES-1:0][5:0]  port_ctl;
  logic [NODES-1:0][5:0]  next_port_ctl;
  logic [NODES-1:0][31:0] name_set;
  logic [NODES-1:0][31:0] next_name_set;
  logic [NODES-1:0][23:0] addr_set;
  logic [NODES-1:0][23:0] next_addr_set;
  logic [NODES-1:0][1:0]  cport_mode;
  logic [NODES-1:0][1:0]  next_cport_mode;
  logic [31:0]            next_prdata;

  // Claim engine state
  jac_state_e             st      [NODES];
  jac_state_e             next_st [NODES];
  logic [NODES-1:0][7:0]  cur_addr;
  logic [NODES-1:0][7:0]  next_cur_addr;
  logic [NODES-1:0][7:0]  attempts;
  logic [NODES-1:0][7:0]  next_attempts;
  logic [NODES-1:0][31:0] wait_cnt;
  logic [NODES-1:0][31:0] next_wait_cnt;
  logic [NODES-1:0]       in_cmd;
  logic [NODES-1:0]       next_in_cmd;
  logic [NODES-1:0]       send_r;
  logic [NODES-1:0]       next_send_r;
  logic [NODES-1:0]       go;
  logic [NODES-1:0]       online;

  // Address setup fields per node
  logic [NODES-1:0][7:0]  pref_addr;
  logic [NODES-1:0][7:0]  alt_lo;
  logic [NODES-1:0][7:0]  alt_hi;
  // High when a lost address has no next step in the range
  logic [NODES-1:0]       range_done;
  // Status word per node as software reads it
  logic [NODES-1:0][31:0] stat_word;

  // Register write strobes
  logic [NODES-1:0]       we_port;
  logic [NODES-1:0]       we_name;
  logic [NODES-1:0]       we_addr;
  logic                   we_cport;
  // Frame may leave: node online and group allowed on that port
  logic [NODES-1:0]       tx_ok;

  // Read data is captured in setup so it stands through the access
  wire logic wr = psel && penable && pwrite;
  wire logic rd = psel && !penable && !pwrite;

  // No wait states: every access ends in its first access cycle
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  // Both command ports share one mode word
  assign we_cport = wr && hit(paddr, OFS_CPORT);

  // Register writes and read data
  always_comb begin
    next_port_ctl   = port_ctl;
    next_name_set   = name_set;
    next_addr_set   = addr_set;
    next_cport_mode = cport_mode;
    next_prdata     = prdata;
    for (int n = 0; n < NODES; n++) begin
      if (we_port[n]) begin
        // Rate sampled at switch-on, held while on bus
        next_port_ctl[n][PC_ON] = pwdata[PC_ON];
        next_port_ctl[n][PC_NODE] = pwdata[PC_NODE];
        next_port_ctl[n][PC_BOUND] = pwdata[PC_BOUND];
        if (!port_ctl[n][PC_ON])
          next_port_ctl[n][3:1] = {1'b0, pwdata[PC_RATE_LO +: 2]};
      end
      // Locked strobes make on-bus setup writes fall away silently
      if (we_name[n])
        next_name_set[n] = pwdata;
      if (we_addr[n])
        next_addr_set[n] = pwdata[23:0];
      if (we_cport)
        next_cport_mode[n] = pwdata[2*n +: 2];
    end
    if (rd) begin
      // Unmapped offsets read as zero
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        OFS_PORT0: next_prdata = {26'h0, port_ctl[0]};
        OFS_PORT1: next_prdata = {26'h0, port_ctl[1]};
        OFS_NAME0: next_prdata = name_set[0];
        OFS_NAME1: next_prdata = name_set[1];
        OFS_ADDR0: next_prdata = {8'h00, addr_set[0]};
        OFS_ADDR1: next_prdata = {8'h00, addr_set[1]};
        OFS_STAT0: next_prdata = stat_word[0];
        OFS_STAT1: next_prdata = stat_word[1];
        OFS_CPORT: next_prdata = {28'h0, cport_mode[1], cport_mode[0]};
        default:   next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < NODES; n++) begin
        port_ctl[n]   <= PORT_RST;
        name_set[n]   <= NAME_RST;
        addr_set[n]   <= ADDR_RST[23:0];
        cport_mode[n] <= CP_DEF;
      end
      prdata <= 32'h0000_0000;
    end else begin
      port_ctl   <= next_port_ctl;
      name_set   <= next_name_set;
      addr_set   <= next_addr_set;
      cport_mode <= next_cport_mode;
      prdata     <= next_prdata;
    end
  end

  // Claim engines, one per node, each bound to its own port
  generate
    for (genvar g = 0; g < NODES; g++) begin : g_node
      // Node g runs when port g is on and bound to it
      assign go[g] = (port_ctl[g][PC_ON] && port_ctl[g][PC_BOUND] &&
                      port_ctl[g][PC_NODE] == 1'(g));
      assign online[g]      = (st[g] == JAC_OWN);
      assign port_enable[g] = port_ctl[g][PC_ON];
      assign port_rate[g]   = port_ctl[g][2:1];
      assign claim_send[g]  = send_r[g];
      assign claim_addr[g]  = cur_addr[g];
      // Transport accepted both ways, broadcast groups never taken in
      assign rx_accept[g]   = rx_valid[g] && online[g] &&
                              !rx_is_nmea[g];

      // Register strobes; setup is locked while the port is on bus
      assign we_port[g]     = wr &&
                              hit(paddr, (g == 0) ? OFS_PORT0 : OFS_PORT1);
      assign we_name[g]     = wr && !port_ctl[g][PC_ON] &&
                              hit(paddr, (g == 0) ? OFS_NAME0 : OFS_NAME1);
      assign we_addr[g]     = wr && !port_ctl[g][PC_ON] &&
                              hit(paddr, (g == 0) ? OFS_ADDR0 : OFS_ADDR1);

      // Claim range of this node
      assign pref_addr[g]   = addr_set[g][AD_PREF +: 8];
      assign alt_lo[g]      = addr_set[g][AD_LO +: 8];
      assign alt_hi[g]      = addr_set[g][AD_HI +: 8];
      // Outside the range, or at its top, ends the stepping, except one below the preferred address
      assign range_done[g]  = (cur_addr[g] < alt_lo[g] ||
                               cur_addr[g] >= alt_hi[g]) &&
                              cur_addr[g] != pref_addr[g] - 8'h01;
      assign stat_word[g]   = {8'h00, attempts[g], cur_addr[g], 6'h00,
                               status_code(st[g])};
      // Offline frames, and unsupported groups on NMEA2000-only ports, are discarded, not queued
      assign tx_ok[g]       = online[tx_node[g]] &&
                              (cport_mode[g] != CP_NMEA_ONLY ||
                               pg_supported(tx_pg));

      always_comb begin
        next_st[g]       = st[g];
        next_cur_addr[g] = cur_addr[g];
        next_attempts[g] = attempts[g];
        next_wait_cnt[g] = wait_cnt[g];
        next_in_cmd[g]   = in_cmd[g];
        next_send_r[g]   = 1'b0;
        // Port off or unbound: the commanded address is forgotten too
        if (!go[g]) begin
          next_st[g]       = JAC_DIS;
          next_cur_addr[g] = ADDR_NULL;
          next_attempts[g] = 8'h00;
          next_in_cmd[g]   = 1'b0;
        end else begin
          unique case (st[g])
            JAC_DIS: begin
              // Every start, restarts too, begins at the preferred address
              next_st[g]       = JAC_CLM;
              next_attempts[g] = 8'h01;
              next_cur_addr[g] = pref_addr[g];
              next_wait_cnt[g] = 32'h0;
              next_send_r[g]   = 1'b1;
            end
            JAC_CLM, JAC_OWN: begin
              // A commanded address wins over a contender in one cycle
              if (cmd_addr_valid[g]) begin
                next_st[g]       = JAC_CLM;
                next_cur_addr[g] = cmd_addr[g];
                next_in_cmd[g]   = 1'b1;
                next_wait_cnt[g] = 32'h0;
                next_send_r[g]   = 1'b1;
              end else if (contend[g]) begin
                // A bumped commanded or held address falls back to the range
                next_in_cmd[g]   = 1'b0;
                next_wait_cnt[g] = 32'h0;
                next_st[g]       = JAC_CLM;
                next_attempts[g] = attempts[g] + 8'h01;
                next_send_r[g]   = 1'b1;
                if (in_cmd[g] || st[g] == JAC_OWN) begin
                  next_cur_addr[g] = alt_lo[g];
                end else if (!range_done[g]) begin
                  next_cur_addr[g] = cur_addr[g] + 8'h01;
                end else if (cur_addr[g] == pref_addr[g] &&
                             alt_lo[g] <= alt_hi[g]) begin
                  // Preferred address lost: go to the bottom of the range
                  next_cur_addr[g] = alt_lo[g];
                end else begin
                  // Nothing left to try; only taking the port off or unbinding it restarts
                  next_st[g]       = JAC_FAIL;
                  next_cur_addr[g] = ADDR_NULL;
                  next_attempts[g] = attempts[g];
                  next_send_r[g]   = 1'b0;
                end
                // A contention step onto the null address fails instead of claiming it
                if (next_cur_addr[g] == ADDR_NULL &&
                    next_st[g] == JAC_CLM) begin
                  next_st[g]     = JAC_FAIL;
                  next_send_r[g] = 1'b0;
                end
              end else if (st[g] == JAC_CLM) begin
                // Quiet for the whole wait: the address is ours
                if (wait_cnt[g] == CLAIM_WAIT - 1)
                  next_st[g] = JAC_OWN;
                else
                  next_wait_cnt[g] = wait_cnt[g] + 32'h1;
              end
            end
            JAC_FAIL: next_st[g] = JAC_FAIL;
            default:  next_st[g] = JAC_DIS;
          endcase
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st[g]       <= JAC_DIS;
          cur_addr[g] <= ADDR_NULL;
          attempts[g] <= 8'h00;
          wait_cnt[g] <= 32'h0;
          in_cmd[g]   <= 1'b0;
          send_r[g]   <= 1'b0;
        end else begin
          st[g]       <= next_st[g];
          cur_addr[g] <= next_cur_addr[g];
          attempts[g] <= next_attempts[g];
          wait_cnt[g] <= next_wait_cnt[g];
          in_cmd[g]   <= next_in_cmd[g];
          send_r[g]   <= next_send_r[g];
        end
      end
    end
  endgenerate

  // Transmit arbitration: only one grant a cycle, lowest port first
  always_comb begin
    logic taken;
    taken    = 1'b0;
    tx_grant = '0;
    tx_drop  = '0;
    for (int p = 0; p < NODES; p++) begin
      if (tx_req[p]) begin
        // Refused requests drop at once so they never block the other port
        if (!tx_ok[p]) begin
          tx_drop[p] = 1'b1;
        end else if (!taken) begin
          tx_grant[p] = 1'b1;
          taken       = 1'b1;
        end
      end
    end
  end

endmodule

//--- jac_pkg.sv
// Package: constants and types for the node address claim block
package jac_pkg;
  localparam int          NODES        = 2;
  localparam logic [7:0]  ADDR_NULL    = 8'hFE;
  localparam logic [7:0]  DEF_ADDR     = 8'h1C;
  localparam logic [2:0]  DEF_IND_GRP  = 3'h2;
  localparam logic [7:0]  DEF_FUNC     = 8'h17;
  localparam logic [6:0]  DEF_DEV_CLS  = 7'h00;
  localparam logic [3:0]  DEF_DEV_INST = 4'h0;
  localparam logic [4:0]  DEF_FN_INST  = 5'h00;
  localparam logic [2:0]  DEF_ECU_INST = 3'h0;
  // Manufacturer code: arbitrary neutral value
  localparam logic [10:0] DEF_MFG      = 11'h001;
  // Bit-rate codes
  localparam logic [1:0]  RATE_250K    = 2'h1;
  localparam logic [1:0]  DEF_RATE     = 2'h1;
  // Claim wait
  localparam int          CLK_MHZ      = 250;
  localparam int          CLAIM_MS     = 250;
  localparam int          CLAIM_CYC    = CLAIM_MS * 1000 * CLK_MHZ;
  // Register map (byte addresses)
  localparam logic [11:0] OFS_PORT0    = 12'h000;
  localparam logic [11:0] OFS_PORT1    = 12'h004;
  localparam logic [11:0] OFS_NAME0    = 12'h008;
  localparam logic [11:0] OFS_NAME1    = 12'h00C;
  localparam logic [11:0] OFS_ADDR0    = 12'h010;
  localparam logic [11:0] OFS_ADDR1    = 12'h014;
  localparam logic [11:0] OFS_STAT0    = 12'h018;
  localparam logic [11:0] OFS_STAT1    = 12'h01C;
  localparam logic [11:0] OFS_CPORT    = 12'h020;
  // Port control fields
  localparam int          PC_ON        = 0;
  localparam int          PC_RATE_LO   = 1;
  localparam int          PC_NODE      = 4;
  localparam int          PC_BOUND     = 5;
  // Address setup fields: [7:0] preferred, [15:8] alt low, [23:16] alt high
  localparam int          AD_PREF      = 0;
  localparam int          AD_LO        = 8;
  localparam int          AD_HI        = 16;
  // Command port mode field: 1 = NMEA2000 output only
  localparam logic [1:0]  CP_NMEA_ONLY = 2'h1;
  localparam logic [1:0]  CP_DEF       = 2'h1;
  // Status codes
  localparam logic [1:0]  ST_DISABLED  = 2'h0;
  localparam logic [1:0]  ST_CLAIMING  = 2'h1;
  localparam logic [1:0]  ST_CLAIMED   = 2'h2;
  localparam logic [1:0]  ST_FAILED    = 2'h3;
  // Supported broadcast groups, 18-bit parameter group numbers
  localparam int          NPG          = 6;
  localparam logic [17:0] PG_TIME      = 18'h1F010;
  localparam logic [17:0] PG_POS_RAP   = 18'h1F801;
  localparam logic [17:0] PG_COG_SOG   = 18'h1F802;
  localparam logic [17:0] PG_DELTA     = 18'h1F803;
  localparam logic [17:0] PG_POS       = 18'h1F805;
  localparam logic [17:0] PG_DIFF      = 18'h1FA0F;
  typedef enum logic [3:0] {
    JAC_DIS   = 4'b0001,
    JAC_CLM   = 4'b0010,
    JAC_OWN   = 4'b0100,
    JAC_FAIL  = 4'b1000
  } jac_state_e;
endpackage

//--- jac_claim_monitor.sv
// Checker of claim sequencing and traffic gating at the block ports
`timescale 1ns/1ns
module jac_claim_monitor
  import jac_pkg::*;
#(
  parameter int CLAIM_WAIT = CLAIM_CYC
) (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // Claim link and port
  input wire logic [NODES-1:0]      claim_send,
  input wire logic [NODES-1:0][7:0] claim_addr,
  input wire logic [NODES-1:0]      contend,
  input wire logic [NODES-1:0]      cmd_addr_valid,
  input wire logic [NODES-1:0][7:0] cmd_addr,
  input wire logic [NODES-1:0]      port_enable,
  // Traffic
  input wire logic [NODES-1:0]      rx_valid,
  input wire logic [NODES-1:0]      rx_is_nmea,
  input wire logic [NODES-1:0]      rx_accept,
  input wire logic [NODES-1:0]      tx_req,
  input wire logic [NODES-1:0]      tx_grant,
  input wire logic [NODES-1:0]      tx_drop
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Quiet cycles on node 0; two cycles of slack for register stages
  int quiet;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet <= 0;
    else if (claim_send[0] || contend[0] || !port_enable[0]) quiet <= 0;
    else if (quiet < CLAIM_WAIT) quiet <= quiet + 1;
  end
  sequence s_cmd0;
    cmd_addr_valid[0] && port_enable[0] && claim_addr[0] != ADDR_NULL;
  endsequence
  sequence s_fail1;
    port_enable[1] && claim_addr[1] == ADDR_NULL &&
    $past(claim_addr[1]) != ADDR_NULL;
  endsequence
  a_accept_gate: assert property (
    rx_accept[0] |-> rx_valid[0] && !rx_is_nmea[0] &&
    quiet >= CLAIM_WAIT - 2)
    else $error("node 0 took traffic before claim settled");
  a_rx_refuse: assert property (
    rx_accept[1] |-> rx_valid[1] && !rx_is_nmea[1])
    else $error("node 1 took a refused input");
  a_tx_priority: assert property (
    tx_grant[1] |-> !tx_req[0] || tx_drop[0])
    else $error("port 1 granted over port 0");
  a_tx_legal: assert property (
    (tx_grant & ~tx_req) == '0 && (tx_grant & tx_drop) == '0)
    else $error("grant without request or when dropped");
  a_off_null: assert property (
    !port_enable[0] && !$past(port_enable[0]) |->
    claim_addr[0] == ADDR_NULL)
    else $error("disabled node 0 shows an address");
  a_addr_moves: assert property (
    $changed(claim_addr[0]) && claim_addr[0] != ADDR_NULL |-> claim_send[0])
    else $error("node 0 address moved without claim frame");
  a_contend_step: assert property (
    contend[0] && port_enable[0] && claim_addr[0] != ADDR_NULL &&
    !cmd_addr_valid[0] |=> claim_send[0])
    else $error("node 0 did not reclaim after contention");
  a_cmd_adopt: assert property (
    s_cmd0 |=> claim_send[0] && claim_addr[0] == $past(cmd_addr[0]))
    else $error("commanded address not adopted");
  a_fail_stop: assert property (
    s_fail1 |=> (claim_addr[1] == ADDR_NULL && !claim_send[1]) [*8])
    else $error("node 1 claimed again after failure");
endmodule
bind jac_node_claim jac_claim_monitor #(.CLAIM_WAIT(CLAIM_WAIT)) mon (
  .pclk(pclk), .presetn(presetn), .claim_send(claim_send),
  .claim_addr(claim_addr), .contend(contend),
  .cmd_addr_valid(cmd_addr_valid), .cmd_addr(cmd_addr),
  .port_enable(port_enable), .rx_valid(rx_valid), .rx_is_nmea(rx_is_nmea),
  .rx_accept(rx_accept), .tx_req(tx_req), .tx_grant(tx_grant),
  .tx_drop(tx_drop));

//--- jac_far_ecu.sv
// Far-side ECU model that contends for addresses it already holds
`timescale 1ns/1ns
module jac_far_ecu (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Claim frames seen on the bus
  input  wire logic       claim_send,
  input  wire logic [7:0] claim_addr,
  // Held address range and answer delay
  input  wire logic [7:0] taken_lo,
  input  wire logic [7:0] taken_hi,
  input  wire logic [2:0] delay,
  // Contending claim
  output logic            contend
);
  logic [3:0] wait_cnt;
  // Answers land well inside the claim wait, as a real contender must
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      contend  <= 1'b0;
    end else begin
      contend <= (wait_cnt == 4'h1);
      if (claim_send && claim_addr >= taken_lo && claim_addr <= taken_hi)
        wait_cnt <= {1'b0, delay} + 4'h1;
      else if (wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule

//--- testbench.sv
// Bench: register setup, address claim and traffic gating
`timescale 1ns/1ns
module testbench
  import jac_pkg::*;
;
  localparam int          CW = 20;
  localparam logic [17:0] PGS [7] = '{PG_TIME, PG_POS_RAP, PG_COG_SOG,
    PG_DELTA, PG_POS, PG_DIFF, 18'h0EA00};
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata;
  logic [17:0]           tx_pg;
  logic [7:0]            seed;
  logic [NODES-1:0]      claim_send, contend, cmd_addr_valid, port_enable;
  logic [NODES-1:0]      rx_valid, rx_is_nmea, rx_accept;
  logic [NODES-1:0]      tx_req, tx_node, tx_grant, tx_drop;
  logic [NODES-1:0][7:0] claim_addr, cmd_addr, taken_lo, taken_hi;
  logic [NODES-1:0][1:0] port_rate;
  logic [63:0]           rq[$];
  logic [7:0]            cq[NODES][$];
  int                    fails, checks_done, k;
  jac_node_claim #(.CLAIM_WAIT(CW)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .claim_send(claim_send), .claim_addr(claim_addr), .contend(contend),
    .cmd_addr_valid(cmd_addr_valid), .cmd_addr(cmd_addr),
    .port_enable(port_enable), .port_rate(port_rate), .rx_valid(rx_valid),
    .rx_is_nmea(rx_is_nmea), .rx_accept(rx_accept), .tx_req(tx_req),
    .tx_node(tx_node), .tx_pg(tx_pg), .tx_grant(tx_grant),
    .tx_drop(tx_drop));
  for (genvar i = 0; i < NODES; i++) begin : g_far
    jac_far_ecu far (.pclk(pclk), .presetn(presetn),
      .claim_send(claim_send[i]), .claim_addr(claim_addr[i]),
      .taken_lo(taken_lo[i]), .taken_hi(taken_hi[i]), .delay(seed[2:0]),
      .contend(contend[i]));
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk_val(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flags(input string nm, input logic [1:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 16) begin
      fails++;
      complete_run();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Expected word is stored pre-masked beside its mask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
    rq.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask
  always @(negedge pclk) begin
    logic [63:0] r;
    if (psel && penable && !pwrite) begin
      r = rq.size() ? rq.pop_front() : '1;
      chk_val("prdata", r[31:0], prdata & r[63:32]);
    end
    for (int i = 0; i < NODES; i++)
      if (claim_send[i] === 1'b1)
        chk_val("claim_addr", {24'h0, cq[i].size() ? cq[i].pop_front() :
          8'hFF}, {24'h0, claim_addr[i]});
  end
  always @(posedge pclk) seed <= lfsr(seed);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    seed = 8'h2C;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cmd_addr_valid, cmd_addr, rx_valid, rx_is_nmea} = '0;
    {tx_req, tx_node, tx_pg} = '0;
    taken_lo = {8'h30, 8'h1C};
    taken_hi = {8'h31, 8'h20};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_STAT0, 32'h0000FE00, '1);
    rd(OFS_STAT1, 32'h0000FE00, '1);
    rd(OFS_ADDR0, 32'h001C1C1C, '1);
    rd(OFS_CPORT, 32'h00000005, 32'h0000000F);
    chk_flags("port_enable", 2'b00, port_enable);
    apb(1'b1, OFS_ADDR0, 32'h0022201C);
    cq[0] = '{8'h1C, 8'h20, 8'h21};
    apb(1'b1, OFS_PORT0, 32'h00000023);
    chk_flags("port_rate", RATE_250K, port_rate[0]);
    tx_req <= 2'b11;
    tx_pg  <= PG_POS;
    @(negedge pclk);
    chk_flags("tx_drop", 2'b11, tx_drop);
    @(posedge pclk);
    apb(1'b1, OFS_ADDR0, {8'h00, {3{seed}}});
    rd(OFS_ADDR0, 32'h0022201C, '1);
    rx_valid <= 2'b01;
    repeat (80) @(posedge pclk);
    rd(OFS_STAT0, 32'h00032102, '1);
    for (k = 0; k < 7; k++) begin
      tx_pg <= PGS[k];
      rx_is_nmea <= {1'b0, k[0]};
      @(negedge pclk);
      chk_flags("tx_grant", k < NPG ? 2'b01 : 2'b00, tx_grant);
      chk_flags("rx_accept", {1'b0, !k[0]}, rx_accept);
      @(posedge pclk);
    end
    tx_node <= 2'b01;
    tx_pg   <= PG_POS;
    @(negedge pclk);
    chk_flags("tx_grant", 2'b10, tx_grant);
    chk_flags("tx_drop", 2'b01, tx_drop);
    @(posedge pclk);
    tx_node <= 2'b00;
    tx_req <= 2'b00;
    cq[0] = '{8'h40};
    cmd_addr[0] <= 8'h40;
    cmd_addr_valid <= 2'b01;
    @(posedge pclk);
    cmd_addr_valid <= 2'b00;
    repeat (40) @(posedge pclk);
    rd(OFS_STAT0, 32'h00004002, 32'h0000FFFF);
    apb(1'b1, OFS_PORT0, 32'h00000022);
    rd(OFS_STAT0, 32'h0000FE00, '1);
    cq[0] = '{8'h1C, 8'h20, 8'h21};
    apb(1'b1, OFS_PORT0, 32'h00000023);
    repeat (80) @(posedge pclk);
    rd(OFS_STAT0, 32'h00032102, '1);
    apb(1'b1, OFS_ADDR1, 32'h00313130);
    cq[1] = '{8'h30, 8'h31};
    apb(1'b1, OFS_PORT1, 32'h00000033);
    repeat (80) @(posedge pclk);
    rd(OFS_STAT1, 32'h0000FE03, 32'h0000FFFF);
    apb(1'b1, 12'hFFC, {24'h0, seed});
    rd(12'hFFC, 32'h0, '1);
    chk_val("claims left", 32'h0, cq[0].size() + cq[1].size());
    complete_run();
  end
endmodule
